// ---- logic/resi_defs.vh ----
`ifndef RESI_DEFS_VH
`define RESI_DEFS_VH

// Register byte offsets
`define RESI_OFF_LINKS      12'h200
`define RESI_OFF_IRQ_SET    12'h304
`define RESI_OFF_IRQ_CLR    12'h308
`define RESI_OFF_CK_RESULT  12'h400
`define RESI_OFF_RX_LADDR   12'h408
`define RESI_OFF_RX_CKVAL   12'h40c
`define RESI_OFF_DA_INDEX   12'h410

// Reset values
`define RESI_RST_LINKS      32'h00000000
`define RESI_RST_IRQ_EN     32'h00000000
`define RESI_RST_RX         32'h00000000

// Link bit positions
`define RESI_LK_RAMPUP_BEGIN   0
`define RESI_LK_DONE_PWRDN     1
`define RESI_LK_PWRDN_TXUP     2
`define RESI_LK_PWRDN_RXUP     3
`define RESI_LK_ADDR_SIGBEGIN  4
`define RESI_LK_DONE_BEGIN     5
`define RESI_LK_ADDR_BCBEGIN   6
`define RESI_LK_PWRDN_SIGHALT  8
`define RESI_LK_TXUP_BEGIN     19
`define RESI_LK_RXUP_BEGIN     20
`define RESI_LK_LAST_PWRDN     21
`define RESI_LK_LAST_BEGIN     22
`define RESI_LINKS_MASK        32'h0078017f

// Event bit positions
`define RESI_EV_RAMPUP_DONE   0
`define RESI_EV_ADDR_SEEN     1
`define RESI_EV_PACKET_DONE   3
`define RESI_EV_POWERED_DOWN  4
`define RESI_EV_TX_PATH_UP    21
`define RESI_EV_RX_PATH_UP    22
`define RESI_EV_LAST_AIR_BIT  27
`define RESI_EVENTS_MASK      32'h086034ff

// Result field widths
`define RESI_LADDR_W   3
`define RESI_CKVAL_W   24
`define RESI_DAI_W     3

`endif

// ---- logic/resi_regs.v ----
// Added by the designer: the APB register port.
`timescale 1ns/100ps
`include "resi_defs.vh"

// Function
// - Rampup done fires transfer begin when linked
// - Packet done fires power down when linked
// - Powered down fires tx rampup when linked
// - Powered down fires rx rampup when linked
// - Address seen starts signal sampling when linked
// - Packet done fires transfer begin when linked
// - Address seen starts bit counter when linked
// - Powered down halts signal sampling when linked
// - Tx path up fires transfer begin when linked
// - Rx path up fires transfer begin when linked
// - Last air bit fires power down when linked
// - Last air bit fires transfer begin when linked
// - Clear register disables, reads enables
// - Read-only checksum verdict of last packet
// - Read-only logical address of last packet
// - Read-only captured checksum field
// - Read-only device address match index
module resi_regs (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [31:0] event_flags,
    input  wire [31:0] event_pulses,
    input  wire        rx_result_valid,
    input  wire        rx_checksum_good,
    input  wire [2:0]  rx_addr_logical,
    input  wire [23:0] rx_checksum_field,
    input  wire [2:0]  rx_dev_index,
    output reg         transfer_begin_task,
    output reg         power_down_task,
    output reg         tx_rampup_task,
    output reg         rx_rampup_task,
    output reg         signal_level_sample_begin_task,
    output reg         signal_level_sample_halt_task,
    output reg         bit_counter_begin_task,
    output reg         irq
);

    reg  [31:0] event_task_links;
    reg  [31:0] irq_enable;
    reg         checksum_result;
    reg  [2:0]  rx_logical_addr;
    reg  [23:0] rx_checksum_value;
    reg  [2:0]  device_addr_hit_index;
    reg  [31:0] next_rdata;
    reg         next_err;

    wire        wr_fire;
    wire        rd_fire;
    wire [31:0] lk;
    wire [31:0] ev;

    assign wr_fire = psel & penable & pwrite & ~pready;
    assign rd_fire = psel & ~penable;
    assign lk      = event_task_links;
    assign ev      = event_pulses;

    // Read mux and unmapped decode
    always @* begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (paddr)
            `RESI_OFF_LINKS:     next_rdata = event_task_links;
            `RESI_OFF_IRQ_SET:   next_rdata = irq_enable;
            `RESI_OFF_IRQ_CLR:   next_rdata = irq_enable;
            `RESI_OFF_CK_RESULT: next_rdata = {31'h00000000, checksum_result};
            `RESI_OFF_RX_LADDR:  next_rdata = {29'h00000000, rx_logical_addr};
            `RESI_OFF_RX_CKVAL:  next_rdata = {8'h00, rx_checksum_value};
            `RESI_OFF_DA_INDEX:  next_rdata = {29'h00000000, device_addr_hit_index};
            default:             next_err   = 1'b1;
        endcase
    end

    // APB handshake: one wait state, answer on second access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            if (rd_fire && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    // Writable registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_task_links <= `RESI_RST_LINKS;
            irq_enable       <= `RESI_RST_IRQ_EN;
        end else if (wr_fire) begin
            if (paddr == `RESI_OFF_LINKS) begin
                event_task_links <= pwdata & `RESI_LINKS_MASK;
            end
            if (paddr == `RESI_OFF_IRQ_SET) begin
                irq_enable <= irq_enable | (pwdata & `RESI_EVENTS_MASK);
            end
            if (paddr == `RESI_OFF_IRQ_CLR) begin
                irq_enable <= irq_enable & ~(pwdata & `RESI_EVENTS_MASK);
            end
        end
    end

    // Receive results captured at end of packet
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            checksum_result       <= 1'b0;
            rx_logical_addr       <= 3'h0;
            rx_checksum_value     <= 24'h000000;
            device_addr_hit_index <= 3'h0;
        end else if (rx_result_valid) begin
            checksum_result       <= rx_checksum_good;
            rx_logical_addr       <= rx_addr_logical;
            rx_checksum_value     <= rx_checksum_field;
            device_addr_hit_index <= rx_dev_index;
        end
    end

    // Shortcut task pulses, one cycle after the event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_begin_task            <= 1'b0;
            power_down_task                <= 1'b0;
            tx_rampup_task                 <= 1'b0;
            rx_rampup_task                 <= 1'b0;
            signal_level_sample_begin_task <= 1'b0;
            signal_level_sample_halt_task  <= 1'b0;
            bit_counter_begin_task         <= 1'b0;
            irq                            <= 1'b0;
        end else begin
            transfer_begin_task <=
                (lk[`RESI_LK_RAMPUP_BEGIN] & ev[`RESI_EV_RAMPUP_DONE])
              | (lk[`RESI_LK_DONE_BEGIN]   & ev[`RESI_EV_PACKET_DONE])
              | (lk[`RESI_LK_TXUP_BEGIN]   & ev[`RESI_EV_TX_PATH_UP])
              | (lk[`RESI_LK_RXUP_BEGIN]   & ev[`RESI_EV_RX_PATH_UP])
              | (lk[`RESI_LK_LAST_BEGIN]   & ev[`RESI_EV_LAST_AIR_BIT]);
            power_down_task <=
                (lk[`RESI_LK_DONE_PWRDN]   & ev[`RESI_EV_PACKET_DONE])
              | (lk[`RESI_LK_LAST_PWRDN]   & ev[`RESI_EV_LAST_AIR_BIT]);
            tx_rampup_task <= lk[`RESI_LK_PWRDN_TXUP] & ev[`RESI_EV_POWERED_DOWN];
            rx_rampup_task <= lk[`RESI_LK_PWRDN_RXUP] & ev[`RESI_EV_POWERED_DOWN];
            signal_level_sample_begin_task <=
                lk[`RESI_LK_ADDR_SIGBEGIN] & ev[`RESI_EV_ADDR_SEEN];
            bit_counter_begin_task <=
                lk[`RESI_LK_ADDR_BCBEGIN] & ev[`RESI_EV_ADDR_SEEN];
            signal_level_sample_halt_task <=
                lk[`RESI_LK_PWRDN_SIGHALT] & ev[`RESI_EV_POWERED_DOWN];
            irq <= |(event_flags & irq_enable);
        end
    end

endmodule // resi_regs

// ---- tb/resi_chk_sva.sv ----
`timescale 1ns/100ps
module resi_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] event_flags,
    input wire [31:0] event_pulses,
    input wire        transfer_begin_task,
    input wire        power_down_task,
    input wire        tx_rampup_task,
    input wire        rx_rampup_task,
    input wire        signal_level_sample_begin_task,
    input wire        signal_level_sample_halt_task,
    input wire        bit_counter_begin_task,
    input wire        irq
);
    wire [31:0] e = event_pulses;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc;
        psel && penable && !pready;
    endsequence
    a_apb_wait: assert property (s_acc |=> pready) else $error("no ready after access");
    a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_begin_cause: assert property (
        transfer_begin_task |-> $past(e[0] | e[3] | e[21] | e[22] | e[27]))
        else $error("transfer begin without event");
    a_down_cause: assert property (
        power_down_task |-> $past(e[3] | e[27])) else $error("power down without event");
    a_tx_cause: assert property (tx_rampup_task |-> $past(e[4]))
        else $error("tx rampup without event");
    a_rx_cause: assert property (rx_rampup_task |-> $past(e[4]))
        else $error("rx rampup without event");
    a_sb_cause: assert property (signal_level_sample_begin_task |-> $past(e[1]))
        else $error("sample begin without event");
    a_bc_cause: assert property (bit_counter_begin_task |-> $past(e[1]))
        else $error("bit counter without event");
    a_sh_cause: assert property (signal_level_sample_halt_task |-> $past(e[4]))
        else $error("sample halt without event");
    a_irq_cause: assert property (irq |-> $past(|event_flags))
        else $error("irq without flag");
endmodule // resi_chk
bind resi_regs resi_chk i_resi_chk (.*);

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`include "resi_defs.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, event_flags, event_pulses, r;
    logic        rx_result_valid, rx_checksum_good;
    logic [2:0]  rx_addr_logical, rx_dev_index;
    logic [23:0] rx_checksum_field;
    logic        transfer_begin_task, power_down_task, tx_rampup_task, rx_rampup_task;
    logic        signal_level_sample_begin_task, signal_level_sample_halt_task;
    logic        bit_counter_begin_task;
    int          mismatches, samples_checked, cyc;
    int          lk[12] = '{0, 1, 2, 3, 4, 5, 6, 8, 19, 20, 21, 22};
    int          ev[12] = '{0, 3, 4, 4, 1, 3, 1, 4, 21, 22, 27, 27};
    logic [6:0]  ex[12] = '{64, 32, 16, 8, 4, 64, 1, 2, 64, 64, 32, 64};
    logic [11:0] offs[7] = '{12'h200, 12'h304, 12'h308, 12'h400, 12'h408, 12'h40c, 12'h410};
    wire  [6:0]  tk = {transfer_begin_task, power_down_task, tx_rampup_task, rx_rampup_task,
        signal_level_sample_begin_task, signal_level_sample_halt_task, bit_counter_begin_task};
    resi_regs i_resi_regs (.*);
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            mismatches++;
            final_report;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic fire(input int n, input logic [6:0] exp);
        logic [6:0] seen;
        seen = 0;
        @(posedge pclk); event_pulses <= 32'h1 << n;
        @(posedge pclk); event_pulses <= 32'h0;
        repeat (3) begin @(posedge pclk); seen |= tk; end
        chk({25'h0, seen}, {25'h0, exp});
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, event_flags, event_pulses} = 0;
        {rx_result_valid, rx_checksum_good, rx_addr_logical, rx_checksum_field} = 0;
        rx_dev_index = 0; presetn = 0;
        repeat (6) @(posedge pclk); presetn <= 1;
        foreach (offs[i]) begin apb(0, offs[i], 0); chk(r, 0); end
        apb(0, 12'h0f0, 0); chk({31'h0, er}, 32'h1);
        chk(r, 0);
        apb(1, 12'h400, 32'hffffffff); apb(0, 12'h400, 0); chk(r, 0);
        apb(1, 12'h200, 32'hffffffff); apb(0, 12'h200, 0); chk(r, `RESI_LINKS_MASK);
        for (int i = 0; i < 12; i++) begin
            apb(1, 12'h200, 0); fire(ev[i], 0);
            apb(1, 12'h200, 32'h1 << lk[i]); fire(ev[i], ex[i]);
        end
        apb(1, 12'h304, 32'hffffffff); apb(0, 12'h304, 0); chk(r, `RESI_EVENTS_MASK);
        apb(0, 12'h308, 0); chk(r, `RESI_EVENTS_MASK);
        apb(1, 12'h308, 0); apb(1, 12'h304, 0); apb(0, 12'h304, 0);
        chk(r, `RESI_EVENTS_MASK);
        apb(1, 12'h308, 32'h1); apb(0, 12'h304, 0); chk(r, `RESI_EVENTS_MASK & ~32'h1);
        event_flags <= 32'h1; repeat (3) @(posedge pclk); chk({31'h0, irq}, 0);
        event_flags <= 32'h2; repeat (3) @(posedge pclk); chk({31'h0, irq}, 1);
        event_flags <= 0;
        rx_checksum_good <= 1; rx_addr_logical <= 5; rx_checksum_field <= 24'ha5c3e1;
        rx_dev_index <= 6; rx_result_valid <= 1; @(posedge pclk); rx_result_valid <= 0;
        apb(0, 12'h400, 0); chk(r, 32'h1);
        apb(0, 12'h408, 0); chk(r, 32'h5);
        apb(0, 12'h40c, 0); chk(r, 32'ha5c3e1);
        apb(0, 12'h410, 0); chk(r, 32'h6);
        rx_checksum_good <= 0; rx_result_valid <= 1; @(posedge pclk); rx_result_valid <= 0;
        apb(0, 12'h400, 0); chk(r, 32'h0);
        final_report;
    end
endmodule // testbench
